// ==== hdl/wtr_counter.sv ====
`timescale 1ns/1ps

module wtr_counter (
    input  wire logic        i_core_clk,
    input  wire logic        i_resetn,
    input  wire logic        i_run,
    input  wire logic        i_updown,
    input  wire logic [15:0] i_period,
    output logic      [15:0] o_count,
    output logic             o_top
);

    wtr_pkg::wtr_cnt_t st;
    wtr_pkg::wtr_cnt_t next_st;

    // ****************************************
    // Count logic
    // ****************************************
    always_comb
    begin
        next_st = st;
        if (!i_updown)
        begin
            next_st.down = 1'b0;
        end
        if (i_run)
        begin
            if (!st.down || !i_updown)
            begin
                if (st.count >= i_period)
                begin
                    // Triangle turns round at the top, sawtooth wraps
                    if (i_updown && (i_period != 16'h0000))
                    begin
                        next_st.down  = 1'b1;
                        next_st.count = st.count - 16'h0001;
                    end
                    else
                    begin
                        next_st.count = 16'h0000;
                    end
                end
                else
                begin
                    next_st.count = st.count + 16'h0001;
                end
            end
            else if (st.count == 16'h0000)
            begin
                next_st.down  = 1'b0;
                next_st.count = 16'h0001;
            end
            else
            begin
                next_st.count = st.count - 16'h0001;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign o_count = st.count;
    assign o_top   = i_run && !st.down && (st.count >= i_period);

endmodule : wtr_counter

// ==== hdl/wtr_defs.svh ====
`ifndef WTR_DEFS_SVH
`define WTR_DEFS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define WTR_OFS_MODE      8'h00
`define WTR_OFS_START     8'h04
`define WTR_OFS_PIN_IO    8'h08
`define WTR_OFS_OUT_EN    8'h0c
`define WTR_OFS_OUT_LVL   8'h10
`define WTR_OFS_PIN_FUNC  8'h14
`define WTR_OFS_PORT_DATA 8'h18
`define WTR_OFS_PORT_DIR  8'h1c
`define WTR_OFS_PERIOD    8'h20
`define WTR_OFS_CMP0      8'h24
`define WTR_OFS_CMP1      8'h28
`define WTR_OFS_CMP2      8'h2c
`define WTR_OFS_STATUS    8'h30

// ****************************************
// Mode codes written to the mode register
// ****************************************
`define WTR_CODE_NORMAL   3'h0
`define WTR_CODE_PWM1     3'h1
`define WTR_CODE_PWM2     3'h2
`define WTR_CODE_PHASE    3'h3
`define WTR_CODE_COMP     3'h4
`define WTR_CODE_RSYNC    3'h5

// ****************************************
// Field positions and pin action codes
// ****************************************
`define WTR_LVL_POS       0
`define WTR_LVL_NEG       1
`define WTR_LVL_CYC       2
`define WTR_STS_CNT_LSB   16
`define WTR_ACT_NONE      2'h0
`define WTR_ACT_LOW       2'h1
`define WTR_ACT_HIGH      2'h2
`define WTR_ACT_TOGGLE    2'h3

// ****************************************
// Reset values
// ****************************************
`define WTR_RST_OUT_EN    7'h7f
`define WTR_RST_PERIOD    16'hffff
`define WTR_RST_CMP       16'h0000

`endif

// ==== hdl/wtr_match_act.sv ====
`timescale 1ns/1ps
`include "wtr_defs.svh"

module wtr_match_act (
    input  wire logic       i_level,
    input  wire logic [1:0] i_act,
    input  wire logic       i_match,
    output logic            o_level
);

    // ****************************************
    // Pin action on a compare match
    // ****************************************
    always_comb
    begin
        o_level = i_level;
        if (i_match)
        begin
            case (i_act)
                `WTR_ACT_LOW:    o_level = 1'b0;
                `WTR_ACT_HIGH:   o_level = 1'b1;
                `WTR_ACT_TOGGLE: o_level = ~i_level;
                default:         o_level = i_level;
            endcase
        end
    end

endmodule : wtr_match_act

// ==== hdl/wtr_pkg.sv ====
package wtr_pkg;

    typedef enum logic [5:0] {
        WTR_NORMAL = 6'h01,
        WTR_PWM1   = 6'h02,
        WTR_PWM2   = 6'h04,
        WTR_PHASE  = 6'h08,
        WTR_COMP   = 6'h10,
        WTR_RSYNC  = 6'h20
    } wtr_mode_t;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [7:0]  address;
        logic [31:0] writedata;
    } wtr_avs_req_t;

    typedef struct packed {
        logic        waitrequest;
        logic [31:0] readdata;
    } wtr_avs_rsp_t;

    typedef struct packed {
        logic [15:0] count;
        logic        down;
    } wtr_cnt_t;

    typedef struct packed {
        wtr_mode_t        mode;
        logic [2:0]       start;
        logic [17:0]      pin_io;
        logic [6:0]       out_en;
        logic [2:0]       out_lvl;
        logic [6:0]       pin_func;
        logic [6:0]       port_data;
        logic [6:0]       port_dir;
        logic [15:0]      period;
        logic [2:0][15:0] cmp;
        logic [5:0]       wave;
        logic             cyc;
        logic [6:0]       pin_out;
        logic [6:0]       pin_oe;
        wtr_avs_rsp_t     rsp;
    } wtr_state_t;

endpackage : wtr_pkg

// ==== hdl/wtr_timer_out.sv ====
`timescale 1ns/1ps
`include "wtr_defs.svh"

// Contract
// - After reset all waveform outputs are low and every pin floats.
// - In PWM mode 1 a pin init write skips the B-side compare pins.
// - In PWM mode 2 a pin init write skips the cycle register pin.
// - Stopping the count in complementary PWM drives its initial output value.
// - Stopping the count in reset-synchronous PWM drives its initial output value.
// - Complementary PWM to normal or PWM 1 forces all outputs low.
// - Reset-sync PWM to normal or PWM 1: positive low, negative high.
// - Reset-sync PWM to complementary PWM drives the cyclic pin low.
// - Complementary PWM waveform changes at compare matches while counting.
// - Reset-sync PWM waveform changes at compare matches while counting.
// - Normal and phase modes: low-on-match action drives a high pin low.

module wtr_timer_out (
    input  wire logic                  i_core_clk,
    input  wire logic                  i_resetn,
    input  wire wtr_pkg::wtr_avs_req_t i_avs_req,
    output logic                       o_avs_waitrequest,
    output logic [31:0]                o_avs_readdata,
    output logic [6:0]                 o_pin_out,
    output logic [6:0]                 o_pin_oe
);

    wtr_pkg::wtr_state_t st;
    wtr_pkg::wtr_state_t next_st;
    logic [2:0][15:0]    cnt;
    logic [2:0]          top;
    logic [5:0]          act_lvl;

    // ****************************************
    // Channel counters and match actions
    // ****************************************
    for (genvar c = 0; c < 3; c++)
    begin : g_cnt
        wtr_counter u_cnt (
            .i_core_clk (i_core_clk),
            .i_resetn   (i_resetn),
            .i_run      (st.start[c]),
            .i_updown   ((c == 0) && (st.mode == wtr_pkg::WTR_COMP)),
            .i_period   (st.period),
            .o_count    (cnt[c]),
            .o_top      (top[c])
        );
    end

    for (genvar i = 0; i < 6; i++)
    begin : g_act
        wtr_match_act u_act (
            .i_level (st.wave[i]),
            .i_act   (st.pin_io[3*i+2 -: 2]),
            .i_match (st.start[i%3] && (cnt[i%3] == st.cmp[i%3])),
            .o_level (act_lvl[i])
        );
    end

    // Pins that a mode leaves alone on init and on match
    function automatic logic held(input wtr_pkg::wtr_mode_t m, input int idx);
        logic r;
        r = 1'b0;
        if ((m == wtr_pkg::WTR_PWM1) && (idx >= 3))
        begin
            r = 1'b1;
        end
        if ((m == wtr_pkg::WTR_PWM2) && (idx == 0))
        begin
            r = 1'b1;
        end
        return r;
    endfunction : held

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        wtr_pkg::wtr_mode_t new_mode;
        logic               mode_ok;
        logic               pwm_mode;
        logic               lvl;
        next_st  = st;
        new_mode = st.mode;
        mode_ok  = 1'b0;
        pwm_mode = (st.mode == wtr_pkg::WTR_COMP) || (st.mode == wtr_pkg::WTR_RSYNC);
        lvl      = 1'b0;

        // Waveform generation
        if (!pwm_mode)
        begin
            for (int i = 0; i < 6; i++)
            begin
                if (!held(st.mode, i))
                begin
                    next_st.wave[i] = act_lvl[i];
                    if (((st.mode == wtr_pkg::WTR_PWM1) || (st.mode == wtr_pkg::WTR_PWM2)) && top[i%3])
                    begin
                        next_st.wave[i] = st.pin_io[3*i];
                    end
                end
            end
        end
        else if (st.start[0])
        begin
            // Sawtooth for reset-sync, triangle for complementary: counter shapes it
            for (int i = 0; i < 3; i++)
            begin
                lvl                 = (cnt[0] < st.cmp[i]);
                next_st.wave[i]     = lvl ? st.out_lvl[`WTR_LVL_POS] : ~st.out_lvl[`WTR_LVL_POS];
                next_st.wave[i+3]   = lvl ? ~st.out_lvl[`WTR_LVL_NEG] : st.out_lvl[`WTR_LVL_NEG];
            end
            if (top[0] && st.out_lvl[`WTR_LVL_CYC])
            begin
                next_st.cyc = ~st.cyc;
            end
        end
        else
        begin
            // Stopped: hold the inactive levels
            next_st.wave = {{3{~st.out_lvl[`WTR_LVL_NEG]}}, {3{~st.out_lvl[`WTR_LVL_POS]}}};
        end

        // Bus slave: one wait cycle, then answer
        next_st.rsp.waitrequest = 1'b1;
        if ((i_avs_req.read || i_avs_req.write) && st.rsp.waitrequest)
        begin
            next_st.rsp.waitrequest = 1'b0;
            next_st.rsp.readdata    = 32'h0000_0000;
            if (i_avs_req.read)
            begin
                if (i_avs_req.address == `WTR_OFS_MODE)
                begin
                    next_st.rsp.readdata[5:0] = st.mode;
                end
                else if (i_avs_req.address == `WTR_OFS_START)
                begin
                    next_st.rsp.readdata[2:0] = st.start;
                end
                else if (i_avs_req.address == `WTR_OFS_PIN_IO)
                begin
                    next_st.rsp.readdata[17:0] = st.pin_io;
                end
                else if (i_avs_req.address == `WTR_OFS_OUT_EN)
                begin
                    next_st.rsp.readdata[6:0] = st.out_en;
                end
                else if (i_avs_req.address == `WTR_OFS_OUT_LVL)
                begin
                    next_st.rsp.readdata[2:0] = st.out_lvl;
                end
                else if (i_avs_req.address == `WTR_OFS_PIN_FUNC)
                begin
                    next_st.rsp.readdata[6:0] = st.pin_func;
                end
                else if (i_avs_req.address == `WTR_OFS_PORT_DATA)
                begin
                    next_st.rsp.readdata[6:0] = st.port_data;
                end
                else if (i_avs_req.address == `WTR_OFS_PORT_DIR)
                begin
                    next_st.rsp.readdata[6:0] = st.port_dir;
                end
                else if (i_avs_req.address == `WTR_OFS_PERIOD)
                begin
                    next_st.rsp.readdata[15:0] = st.period;
                end
                else if (i_avs_req.address == `WTR_OFS_CMP0)
                begin
                    next_st.rsp.readdata[15:0] = st.cmp[0];
                end
                else if (i_avs_req.address == `WTR_OFS_CMP1)
                begin
                    next_st.rsp.readdata[15:0] = st.cmp[1];
                end
                else if (i_avs_req.address == `WTR_OFS_CMP2)
                begin
                    next_st.rsp.readdata[15:0] = st.cmp[2];
                end
                else if (i_avs_req.address == `WTR_OFS_STATUS)
                begin
                    next_st.rsp.readdata[6:0]                     = {st.cyc, st.wave};
                    next_st.rsp.readdata[`WTR_STS_CNT_LSB +: 16] = cnt[0];
                end
            end
            else
            begin
                if (i_avs_req.address == `WTR_OFS_MODE)
                begin
                    mode_ok = 1'b1;
                    case (i_avs_req.writedata[2:0])
                        `WTR_CODE_NORMAL: new_mode = wtr_pkg::WTR_NORMAL;
                        `WTR_CODE_PWM1:   new_mode = wtr_pkg::WTR_PWM1;
                        `WTR_CODE_PWM2:   new_mode = wtr_pkg::WTR_PWM2;
                        `WTR_CODE_PHASE:  new_mode = wtr_pkg::WTR_PHASE;
                        `WTR_CODE_COMP:   new_mode = wtr_pkg::WTR_COMP;
                        `WTR_CODE_RSYNC:  new_mode = wtr_pkg::WTR_RSYNC;
                        default:          mode_ok  = 1'b0;
                    endcase
                    if (mode_ok)
                    begin
                        if ((new_mode == wtr_pkg::WTR_NORMAL) || (new_mode == wtr_pkg::WTR_PWM1))
                        begin
                            if (st.mode == wtr_pkg::WTR_COMP)
                            begin
                                next_st.wave = 6'h00;
                                next_st.cyc  = 1'b0;
                            end
                            else if (st.mode == wtr_pkg::WTR_RSYNC)
                            begin
                                next_st.wave = 6'h38;
                            end
                        end
                        if ((st.mode == wtr_pkg::WTR_RSYNC) && (new_mode == wtr_pkg::WTR_COMP))
                        begin
                            next_st.cyc = 1'b0;
                        end
                        next_st.mode = new_mode;
                    end
                end
                else if (i_avs_req.address == `WTR_OFS_START)
                begin
                    next_st.start = i_avs_req.writedata[2:0];
                end
                else if (i_avs_req.address == `WTR_OFS_PIN_IO)
                begin
                    next_st.pin_io = i_avs_req.writedata[17:0];
                    for (int i = 0; i < 6; i++)
                    begin
                        if (!held(st.mode, i))
                        begin
                            next_st.wave[i] = i_avs_req.writedata[3*i];
                        end
                    end
                end
                else if (i_avs_req.address == `WTR_OFS_OUT_EN)
                begin
                    next_st.out_en = i_avs_req.writedata[6:0];
                end
                else if (i_avs_req.address == `WTR_OFS_OUT_LVL)
                begin
                    next_st.out_lvl = i_avs_req.writedata[2:0];
                end
                else if (i_avs_req.address == `WTR_OFS_PIN_FUNC)
                begin
                    next_st.pin_func = i_avs_req.writedata[6:0];
                end
                else if (i_avs_req.address == `WTR_OFS_PORT_DATA)
                begin
                    next_st.port_data = i_avs_req.writedata[6:0];
                end
                else if (i_avs_req.address == `WTR_OFS_PORT_DIR)
                begin
                    next_st.port_dir = i_avs_req.writedata[6:0];
                end
                else if (i_avs_req.address == `WTR_OFS_PERIOD)
                begin
                    next_st.period = i_avs_req.writedata[15:0];
                end
                else if (i_avs_req.address == `WTR_OFS_CMP0)
                begin
                    next_st.cmp[0] = i_avs_req.writedata[15:0];
                end
                else if (i_avs_req.address == `WTR_OFS_CMP1)
                begin
                    next_st.cmp[1] = i_avs_req.writedata[15:0];
                end
                else if (i_avs_req.address == `WTR_OFS_CMP2)
                begin
                    next_st.cmp[2] = i_avs_req.writedata[15:0];
                end
            end
        end

        // Pin mux from the next levels, so a mode change lands on one edge
        for (int p = 0; p < 7; p++)
        begin
            if (next_st.pin_func[p])
            begin
                next_st.pin_out[p] = (p < 6) ? next_st.wave[p] : next_st.cyc;
                next_st.pin_oe[p]  = next_st.out_en[p];
            end
            else
            begin
                next_st.pin_out[p] = next_st.port_data[p];
                next_st.pin_oe[p]  = next_st.port_dir[p];
            end
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            st                 <= '0;
            st.mode            <= wtr_pkg::WTR_NORMAL;
            st.out_en          <= `WTR_RST_OUT_EN;
            st.period          <= `WTR_RST_PERIOD;
            st.cmp             <= {3{`WTR_RST_CMP}};
            st.rsp.waitrequest <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign o_avs_waitrequest = st.rsp.waitrequest;
    assign o_avs_readdata    = st.rsp.readdata;
    assign o_pin_out         = st.pin_out;
    assign o_pin_oe          = st.pin_oe;

endmodule : wtr_timer_out

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
`include "wtr_defs.svh"

module tb_top;
    typedef struct packed {
        logic        wr;
        logic [7:0]  addr;
        logic [31:0] data;
        logic [31:0] exp;
    } wtr_row_t;

    logic                  i_core_clk = 1'b0;
    logic                  i_resetn;
    wtr_pkg::wtr_avs_req_t req;
    logic                  o_wait;
    logic [31:0]           o_rd;
    logic [6:0]            pin_out;
    logic [6:0]            pin_oe;
    logic [6:0]            line;
    logic [31:0]           q;
    logic [15:0]           held;
    int                    n_errors;
    int                    total_checks;
    int                    cycles;

    // ****************************************
    // Rows: reset values, each mode code, a bad code, an unmapped place
    // ****************************************
    wtr_row_t rows [12] = '{
        '{1'b0, `WTR_OFS_OUT_EN, 32'h0, 32'h7f}, '{1'b0, `WTR_OFS_PERIOD, 32'h0, 32'hffff},
        '{1'b0, `WTR_OFS_CMP0, 32'h0, 32'h0}, '{1'b0, `WTR_OFS_MODE, 32'h0, 32'h1},
        '{1'b1, `WTR_OFS_MODE, 32'h0, 32'h1}, '{1'b1, `WTR_OFS_MODE, 32'h1, 32'h2},
        '{1'b1, `WTR_OFS_MODE, 32'h2, 32'h4}, '{1'b1, `WTR_OFS_MODE, 32'h3, 32'h8},
        '{1'b1, `WTR_OFS_MODE, 32'h4, 32'h10}, '{1'b1, `WTR_OFS_MODE, 32'h5, 32'h20},
        '{1'b1, `WTR_OFS_MODE, 32'h6, 32'h20}, '{1'b1, 8'h40, 32'h5a, 32'h0}};

    wtr_timer_out u_dut (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_avs_req(req),
        .o_avs_waitrequest(o_wait), .o_avs_readdata(o_rd), .o_pin_out(pin_out), .o_pin_oe(pin_oe));
    wtr_power_stage u_load (.i_pin_out(pin_out), .i_pin_oe(pin_oe), .o_line(line));

    always #50 i_core_clk = ~i_core_clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Held until waitrequest is sampled low; only the bench timeout ends a hang
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        req <= '{read: !wr, write: wr, address: a, writedata: d};
        do @(posedge i_core_clk);
        while (o_wait !== 1'b0);
        q = o_rd;
        req <= '0;
    endtask : bus

    task automatic wait_status(input logic [31:0] mask, input logic [31:0] val);
        bus(1'b0, `WTR_OFS_STATUS, 32'h0);
        repeat (99) if ((q & mask) !== val) bus(1'b0, `WTR_OFS_STATUS, 32'h0);
        check(q & mask, val);
    endtask : wait_status

    task automatic enter_pair(input logic [31:0] lvl, input logic [31:0] code);
        bus(1'b1, `WTR_OFS_OUT_EN, 32'h0);
        bus(1'b1, `WTR_OFS_OUT_LVL, lvl);
        bus(1'b1, `WTR_OFS_MODE, code);
        bus(1'b1, `WTR_OFS_OUT_EN, 32'h7f);
        bus(1'b1, `WTR_OFS_PIN_FUNC, 32'h7f);
        bus(1'b1, `WTR_OFS_START, 32'h1);
    endtask : enter_pair

    task automatic finish_test();
        $display("Checks %0d, errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test

    always @(posedge i_core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            finish_test();
        end
    end

    initial
    begin
        i_resetn = 1'b0;
        req = '0;
        repeat (12) @(posedge i_core_clk);
        i_resetn <= 1'b1;
        @(posedge i_core_clk);
        check({18'h0, pin_oe, pin_out}, 32'h0);
        check({25'h0, line}, 32'h0);
        foreach (rows[i])
        begin
            if (rows[i].wr) bus(1'b1, rows[i].addr, rows[i].data);
            bus(1'b0, rows[i].addr, 32'h0);
            check(q, rows[i].exp);
        end
        // ****************************************
        // Normal: high pin drops on match, count holds; phase: high pin drops on match
        // ****************************************
        bus(1'b1, `WTR_OFS_MODE, 32'h0);
        bus(1'b1, `WTR_OFS_PERIOD, 32'h10);
        bus(1'b1, `WTR_OFS_CMP0, 32'h5);
        bus(1'b1, `WTR_OFS_PIN_IO, 32'h3);
        bus(1'b1, `WTR_OFS_PIN_FUNC, 32'h7f);
        check({25'h0, line}, 32'h1);
        bus(1'b1, `WTR_OFS_START, 32'h1);
        wait_status(32'h1, 32'h0);
        bus(1'b1, `WTR_OFS_START, 32'h0);
        bus(1'b0, `WTR_OFS_STATUS, 32'h0);
        held = q[31:16];
        repeat (5) @(posedge i_core_clk);
        wait_status(32'hffff0000, {held, 16'h0});
        bus(1'b1, `WTR_OFS_MODE, 32'h3);
        bus(1'b1, `WTR_OFS_PIN_IO, 32'h18);
        bus(1'b1, `WTR_OFS_START, 32'h2);
        wait_status(32'h2, 32'h0);
        bus(1'b1, `WTR_OFS_START, 32'h0);
        // ****************************************
        // Pin init in PWM 1 and PWM 2
        // ****************************************
        bus(1'b1, `WTR_OFS_PIN_IO, 32'h09249);
        bus(1'b1, `WTR_OFS_MODE, 32'h1);
        bus(1'b1, `WTR_OFS_PIN_IO, 32'h0);
        wait_status(32'h3f, 32'h38);
        bus(1'b1, `WTR_OFS_MODE, 32'h2);
        bus(1'b1, `WTR_OFS_PIN_IO, 32'h09249);
        wait_status(32'h3f, 32'h3e);
        // ****************************************
        // Complementary error recovery
        // ****************************************
        enter_pair(32'h0, 32'h4);
        wait_status(32'h1, 32'h0);
        wait_status(32'h1, 32'h1);
        bus(1'b1, `WTR_OFS_PORT_DATA, 32'h7f);
        bus(1'b1, `WTR_OFS_PORT_DIR, 32'h7f);
        bus(1'b1, `WTR_OFS_PIN_FUNC, 32'h0);
        check({25'h0, line}, 32'h7f);
        bus(1'b1, `WTR_OFS_START, 32'h0);
        wait_status(32'h3f, 32'h3f);
        bus(1'b1, `WTR_OFS_PIN_FUNC, 32'h7f);
        bus(1'b1, `WTR_OFS_MODE, 32'h0);
        wait_status(32'h7f, 32'h0);
        check({25'h0, pin_out}, 32'h0);
        // ****************************************
        // Reset-sync error recovery
        // ****************************************
        enter_pair(32'h4, 32'h5);
        wait_status(32'h40, 32'h40);
        wait_status(32'h1, 32'h0);
        bus(1'b1, `WTR_OFS_START, 32'h0);
        wait_status(32'h3f, 32'h3f);
        bus(1'b1, `WTR_OFS_MODE, 32'h0);
        wait_status(32'h3f, 32'h38);
        enter_pair(32'h4, 32'h5);
        wait_status(32'h40, 32'h40);
        bus(1'b1, `WTR_OFS_START, 32'h0);
        bus(1'b1, `WTR_OFS_MODE, 32'h4);
        wait_status(32'h40, 32'h0);
        bus(1'b1, `WTR_OFS_START, 32'h1);
        repeat (8) @(posedge i_core_clk);
        bus(1'b1, `WTR_OFS_START, 32'h0);
        wait_status(32'h3f, 32'h3f);
        finish_test();
    end
endmodule : tb_top

// ==== verification/wtr_power_stage.sv ====
`timescale 1ns/1ps

module wtr_power_stage (
    input  wire logic [6:0] i_pin_out,
    input  wire logic [6:0] i_pin_oe,
    output logic      [6:0] o_line
);
    // ****************************************
    // Gate inputs of the stage
    // ****************************************
    // Pull-downs hold a floating gate low
    assign o_line = i_pin_oe & i_pin_out;
endmodule : wtr_power_stage

// ==== verification/wtr_timer_out_props.sv ====
`timescale 1ns/1ps
`include "wtr_defs.svh"

module wtr_timer_out_props (
    input  wire logic                  i_core_clk,
    input  wire logic                  i_resetn,
    input  wire wtr_pkg::wtr_avs_req_t i_avs_req,
    input  wire logic                  o_avs_waitrequest,
    input  wire logic [31:0]           o_avs_readdata,
    input  wire logic [6:0]            o_pin_out,
    input  wire logic [6:0]            o_pin_oe
);
    // ****************************************
    // Settings shadow
    // ****************************************
    logic [2:0] mode_sh;
    logic [2:0] lvl_sh;
    logic       run0_sh;
    logic       func_sh;
    logic       take_wr;
    logic       take_any;
    assign take_wr  = i_avs_req.write && o_avs_waitrequest;
    assign take_any = (i_avs_req.read || i_avs_req.write) && o_avs_waitrequest;
    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            mode_sh <= `WTR_CODE_NORMAL;
            lvl_sh  <= 3'h0;
            run0_sh <= 1'b0;
            func_sh <= 1'b0;
        end
        else if (take_wr)
        begin
            case (i_avs_req.address)
                `WTR_OFS_MODE:     if (i_avs_req.writedata[2:0] <= `WTR_CODE_RSYNC) mode_sh <= i_avs_req.writedata[2:0];
                `WTR_OFS_START:    run0_sh <= i_avs_req.writedata[0];
                `WTR_OFS_OUT_LVL:  lvl_sh <= i_avs_req.writedata[2:0];
                `WTR_OFS_PIN_FUNC: func_sh <= (i_avs_req.writedata[6:0] == 7'h7f);
                default:           ;
            endcase
        end
    end

    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);

    sequence s_take_wr(logic [7:0] ofs);
        take_wr && i_avs_req.address == ofs;
    endsequence
    // Pins on the timer, else port data hides the wave
    sequence s_stop_in(logic [2:0] m);
        s_take_wr(`WTR_OFS_START) ##0 (!i_avs_req.writedata[0] && run0_sh && func_sh && mode_sh == m);
    endsequence
    sequence s_leave(logic [2:0] m);
        s_take_wr(`WTR_OFS_MODE) ##0 (mode_sh == m && !run0_sh && func_sh);
    endsequence

    a_reset_pins_low: assert property ($rose(i_resetn) |-> o_pin_out == 7'h00 && o_pin_oe == 7'h00)
        else $error("pins not idle after reset");
    a_wait_answer: assert property (take_any |=> !o_avs_waitrequest)
        else $error("no answer to a request");
    a_wait_single: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("waitrequest low too long");
    a_wait_idle: assert property (!(i_avs_req.read || i_avs_req.write) && o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("answer without request");
    a_comp_stop: assert property (s_stop_in(`WTR_CODE_COMP) |-> ##[1:3]
        o_pin_out[5:0] == {{3{~lvl_sh[1]}}, {3{~lvl_sh[0]}}}) else $error("comp stop level wrong");
    a_rsync_stop: assert property (s_stop_in(`WTR_CODE_RSYNC) |-> ##[1:3]
        o_pin_out[5:0] == {{3{~lvl_sh[1]}}, {3{~lvl_sh[0]}}}) else $error("reset-sync stop level wrong");
    a_comp_exit: assert property (s_leave(`WTR_CODE_COMP) ##0 (i_avs_req.writedata[2:0] <= `WTR_CODE_PWM1)
        |-> ##[1:3] o_pin_out == 7'h00) else $error("outputs not low leaving comp");
    a_rsync_exit: assert property (s_leave(`WTR_CODE_RSYNC) ##0 (i_avs_req.writedata[2:0] <= `WTR_CODE_PWM1)
        |-> ##[1:3] o_pin_out[5:0] == 6'h38) else $error("phase levels wrong leaving reset-sync");
    a_rsync_comp: assert property (s_leave(`WTR_CODE_RSYNC) ##0 (i_avs_req.writedata[2:0] == `WTR_CODE_COMP)
        |-> ##[1:3] !o_pin_out[6]) else $error("cyclic pin not low entering comp");
endmodule : wtr_timer_out_props

bind wtr_timer_out wtr_timer_out_props u_props (
    .i_core_clk        (i_core_clk),
    .i_resetn          (i_resetn),
    .i_avs_req         (i_avs_req),
    .o_avs_waitrequest (o_avs_waitrequest),
    .o_avs_readdata    (o_avs_readdata),
    .o_pin_out         (o_pin_out),
    .o_pin_oe          (o_pin_oe)
);
